// [src/acp_pkg.sv]
// register map, field layout and carriers of the serial channel pair
package acp_pkg;
   localparam int unsigned NUM_CH = 2;
   // i/o offsets of channel 0, channel 1 sits at base plus one
   localparam logic [5:0] OFS_CTRL_A   = 6'h00;
   localparam logic [5:0] OFS_CTRL_B   = 6'h02;
   localparam logic [5:0] OFS_STATUS   = 6'h04;
   localparam logic [5:0] OFS_TX_DATA  = 6'h06;
   localparam logic [5:0] OFS_RX_DATA  = 6'h08;
   localparam logic [5:0] OFS_LAST_CH  = 6'h09;
   localparam logic [5:0] OFS_EXT_CTRL = 6'h12;
   // control a
   localparam int unsigned CA_MP_ENABLE = 7;
   localparam int unsigned CA_RX_ENABLE = 6;
   localparam int unsigned CA_TX_ENABLE = 5;
   localparam int unsigned CA_RTS_CKDIS = 4;
   localparam int unsigned CA_ERR_RESET = 3;
   localparam int unsigned CA_DATA8     = 2;
   localparam int unsigned CA_PARITY    = 1;
   localparam int unsigned CA_STOP2     = 0;
   // control b
   localparam int unsigned CB_MP_TX_BIT  = 7;
   localparam int unsigned CB_MP_MODE    = 6;
   localparam int unsigned CB_PARITY_ODD = 4;
   localparam int unsigned CB_DIV64      = 3;
   localparam logic [2:0]  EXT_CLK_CODE  = 3'h7;
   // status
   localparam int unsigned ST_RX_FULL  = 7;
   localparam int unsigned ST_OVERRUN  = 6;
   localparam int unsigned ST_PAR_ERR  = 5;
   localparam int unsigned ST_FRM_ERR  = 4;
   localparam int unsigned ST_RX_IE    = 3;
   localparam int unsigned ST_CLEAR_TO_SEND_CH1_SEL = 2;
   localparam int unsigned ST_TX_EMPTY = 1;
   localparam int unsigned ST_TX_IE    = 0;
   // extension control, channel 0
   localparam int unsigned EXT_RX_FULL_INH = 7;
   localparam int unsigned EXT_CARRIER_ADV = 6;
   localparam int unsigned EXT_CTS_ADV     = 5;
   localparam int unsigned EXT_X1_CLOCK    = 4;
   localparam logic [7:0]  EXT_WR_MASK     = 8'hfd;
   // reset values
   localparam logic [7:0] RST_CTRL_A = 8'h10;
   localparam logic [7:0] RST_CTRL_B = 8'h00;
   localparam logic [7:0] RST_EXT    = 8'h00;
   // sub-bit tick counts per bit
   localparam logic [6:0] OSR_X1 = 7'h01;
   localparam logic [6:0] OSR_16 = 7'h10;
   localparam logic [6:0] OSR_64 = 7'h40;

   typedef enum logic [3:0] {
      RX_IDLE  = 4'b0001,
      RX_START = 4'b0010,
      RX_BITS  = 4'b0100,
      RX_STOP  = 4'b1000
   } acp_rx_state_e;

   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } acp_io_req_s;

   typedef struct packed {
      logic txd;
      logic irq;
      logic rx_dma_req;
      logic tx_dma_req;
   } acp_ch_out_s;
endpackage : acp_pkg

// [src/acp_top.sv]
// two asynchronous serial channels with register bank and modem lines
//
// Behaviour
// - two independent full-duplex channels, own registers
// - seven or eight data bits per character
// - software ninth bit marks address characters
// - bit period of 16 or 64 ticks, or 1 tick with channel 0 x1 external clock
// - channel 0 carrier/cts/rts; channel 1 cts
// - parity, overrun, framing errors flagged separately
// - framing flag on zero stop; cleared as listed
// - receive interrupt enable raises request on flags
// - carrier rising edge also requests, channel 0
// - cts select routes shared pin
// - tx empty clears on write, sets on load
// - tx empty forced high in stop mode
// - tx empty low while cts high
// - transmit dma request while tx empty, transmit enable not checked
// - channel registers at offsets 00h to 09h
// - extension register at 12h, resets zero
// - clock pins toggle once per tick, shared dma
// - dma transfer requests per channel
// - inhibit bit stops full-flag receive request
// - receive dma blocked by error flags
// - full flag set while buffer holds characters
// - prescale 2 to the code, all-ones external
`timescale 1ns/1ps
module acp_top #(
   parameter int unsigned RX_BUF_DEPTH = 2
) (
   // clock and reset
   input  wire logic                  ref_clk,
   input  wire logic                  rstn,
   // internal i/o register port
   input  wire acp_pkg::acp_io_req_s  io_req,
   output logic [7:0]                 io_rdata_ff,
   input  wire logic                  io_stop_mode,
   // serial data and modem pins
   input  wire logic [1:0]            rxd,
   input  wire logic                  carrier_detect_ch0_n,
   input  wire logic                  clear_to_send_ch0_n,
   input  wire logic                  clear_to_send_ch1_shared_n,
   output logic                       request_to_send_ch0_n_ff,
   output logic                       clocked_serial_rx_in_ff,
   // serial clock pins and their dma sharing
   input  wire logic [1:0]            ck_pin_i,
   output logic [1:0]                 ck_pin_o_ff,
   output logic [1:0]                 ck_pin_oe_ff,
   input  wire logic                  ck0_dma_sel,
   input  wire logic                  ck1_dma_sel,
   output logic                       dma_request_in_0_ff,
   input  wire logic                  dma_end_out_0,
   // per-channel line, request and dma outputs
   output acp_pkg::acp_ch_out_s [1:0] ch_out_ff
);
   localparam int unsigned AW = $clog2(RX_BUF_DEPTH);

   if (RX_BUF_DEPTH < 2 || (RX_BUF_DEPTH & (RX_BUF_DEPTH - 1)) != 0) begin : g_chk
      $error("RX_BUF_DEPTH must be a power of two, at least 2");
   end

   function automatic logic acc(input logic stb, input logic [5:0] a,
                                input logic [5:0] base, input logic ch);
      return stb && (a == (base | {5'h00, ch}));
   endfunction : acc

   logic [6:0]           sync1_ff;
   logic [6:0]           sync2_ff;
   logic [1:0]           ck_prev_ff;
   logic                 dcd_prev_ff;
   logic [5:0]           ofs;
   logic                 dcd_hi;
   logic [7:0]           ext_ff;
   logic [7:0]           rd_mux;
   logic [7:0]           ctrl_a_ff  [2];
   logic [7:0]           ctrl_b_ff  [2];
   logic [7:0]           status     [2];
   logic [7:0]           rx_head    [2];
   logic                 mpb_rx_ff  [2];
   logic                 nxt_ck_o   [2];
   logic                 nxt_ck_oe  [2];
   logic                 clear_to_send_ch1_sel_ff;
   acp_pkg::acp_ch_out_s nxt_ch_out [2];

   assign ofs    = io_req.addr[5:0];
   assign dcd_hi = sync2_ff[2];

   // pin synchronisers, idle high
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         sync1_ff <= 7'h7f;
         sync2_ff <= 7'h7f;
      end else begin
         sync1_ff <= {ck_pin_i, clear_to_send_ch1_shared_n, clear_to_send_ch0_n,
                      carrier_detect_ch0_n, rxd};
         sync2_ff <= sync1_ff;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ck_prev_ff  <= 2'h3;
         dcd_prev_ff <= 1'b1;
      end else begin
         ck_prev_ff  <= sync2_ff[6:5];
         dcd_prev_ff <= dcd_hi;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ext_ff <= acp_pkg::RST_EXT;
      end else if (io_req.wr && ofs == acp_pkg::OFS_EXT_CTRL) begin
         ext_ff <= io_req.wdata & acp_pkg::EXT_WR_MASK;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         clear_to_send_ch1_sel_ff <= 1'b0;
      end else if (acc(io_req.wr, ofs, acp_pkg::OFS_STATUS, 1'b1)) begin
         clear_to_send_ch1_sel_ff <= io_req.wdata[acp_pkg::ST_CLEAR_TO_SEND_CH1_SEL];
      end
   end

   // register read, channel picked by the low offset bit
   always_comb begin
      rd_mux = 8'h00;
      if (ofs <= acp_pkg::OFS_LAST_CH) begin
         case ({ofs[5:1], 1'b0})
            acp_pkg::OFS_CTRL_A:  rd_mux = {ctrl_a_ff[ofs[0]][7:4], mpb_rx_ff[ofs[0]],
                                            ctrl_a_ff[ofs[0]][2:0]};
            acp_pkg::OFS_CTRL_B:  rd_mux = ctrl_b_ff[ofs[0]];
            acp_pkg::OFS_STATUS:  rd_mux = status[ofs[0]];
            acp_pkg::OFS_RX_DATA: rd_mux = rx_head[ofs[0]];
            default:              rd_mux = 8'h00;
         endcase
      end else if (ofs == acp_pkg::OFS_EXT_CTRL) begin
         rd_mux = ext_ff;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         io_rdata_ff <= 8'h00;
      end else if (io_req.rd) begin
         io_rdata_ff <= rd_mux;
      end
   end

   // pin outputs
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ch_out_ff                <= '0;
         ck_pin_o_ff              <= 2'h0;
         ck_pin_oe_ff             <= 2'h0;
         request_to_send_ch0_n_ff <= 1'b1;
         clocked_serial_rx_in_ff  <= 1'b1;
         dma_request_in_0_ff      <= 1'b1;
      end else begin
         for (int i = 0; i < 2; i++) begin
            ch_out_ff[i]    <= nxt_ch_out[i];
            ck_pin_o_ff[i]  <= nxt_ck_o[i];
            ck_pin_oe_ff[i] <= nxt_ck_oe[i];
         end
         request_to_send_ch0_n_ff <= ctrl_a_ff[0][acp_pkg::CA_RTS_CKDIS];
         clocked_serial_rx_in_ff  <= clear_to_send_ch1_sel_ff ? 1'b1 : sync2_ff[4];
         dma_request_in_0_ff      <= ck0_dma_sel ? sync2_ff[5] : 1'b1;
      end
   end

   for (genvar c = 0; c < 2; c++) begin : g_ch
      localparam logic CH = 1'(c);
      logic                  wr_a, wr_b, wr_s, wr_t, rd_s, rd_r;
      logic                  data8, par_en, mp, ext_sel, x1, tick, tx_empty_flag, cts_hi;
      logic                  rx_on, err_clr, done, keep, pop, push, buf_full;
      logic [6:0]            osr;
      logic [5:0]            ps_cnt_ff, ps_lim;
      logic                  ck_tgl_ff, rie_ff, tie_ff, tdr_full_ff, tx_busy_ff;
      logic                  overrun_flag_ff, pe_ff, fe_ff, dcd_rise_ff;
      logic [7:0]            tdr_ff, rx_data;
      logic [11:0]           tx_sh_ff;
      logic [3:0]            tx_left_ff, rx_idx_ff, nbits;
      logic [6:0]            tx_sub_ff, rx_sub_ff;
      logic [8:0]            rx_sh_ff;
      logic                  rx_x, rxd_s, perr;
      acp_pkg::acp_rx_state_e rx_st_ff;
      logic [7:0]            mem_ff [RX_BUF_DEPTH];
      logic [AW-1:0]         wp_ff, rp_ff;
      logic [AW:0]           cnt_ff;

      assign wr_a = acc(io_req.wr, ofs, acp_pkg::OFS_CTRL_A, CH);
      assign wr_b = acc(io_req.wr, ofs, acp_pkg::OFS_CTRL_B, CH);
      assign wr_s = acc(io_req.wr, ofs, acp_pkg::OFS_STATUS, CH);
      assign wr_t = acc(io_req.wr, ofs, acp_pkg::OFS_TX_DATA, CH);
      assign rd_s = acc(io_req.rd, ofs, acp_pkg::OFS_STATUS, CH);
      assign rd_r = acc(io_req.rd, ofs, acp_pkg::OFS_RX_DATA, CH);

      assign data8   = ctrl_a_ff[c][acp_pkg::CA_DATA8];
      assign mp      = ctrl_b_ff[c][acp_pkg::CB_MP_MODE];
      assign par_en  = ctrl_a_ff[c][acp_pkg::CA_PARITY] & ~mp;
      assign ext_sel = ctrl_b_ff[c][2:0] == acp_pkg::EXT_CLK_CODE;
      assign x1      = (c == 0) && ext_sel && ext_ff[acp_pkg::EXT_X1_CLOCK];
      assign osr     = x1 ? acp_pkg::OSR_X1 : ctrl_b_ff[c][acp_pkg::CB_DIV64] ?
                       acp_pkg::OSR_64 : acp_pkg::OSR_16;
      assign ps_lim  = 6'((7'h01 << ctrl_b_ff[c][2:0]) - 7'h01);
      assign tick    = ext_sel ? (sync2_ff[5+c] & ~ck_prev_ff[c]) : (ps_cnt_ff == ps_lim);
      assign nbits   = (data8 ? 4'h8 : 4'h7) + {3'h0, par_en | mp};
      assign rxd_s   = sync2_ff[c];

      // modem lines; advisory bits stop cts holding tx and carrier disabling rx
      assign cts_hi = (c == 0) ? (sync2_ff[3] & ~ext_ff[acp_pkg::EXT_CTS_ADV])
                               : (clear_to_send_ch1_sel_ff & sync2_ff[4]);
      assign rx_on  = ctrl_a_ff[c][acp_pkg::CA_RX_ENABLE] & ~io_stop_mode &
                      ~((c == 0) && dcd_hi && !ext_ff[acp_pkg::EXT_CARRIER_ADV]);
      assign tx_empty_flag   = io_stop_mode | (~tdr_full_ff & ~cts_hi);
      assign err_clr = (wr_a & ~io_req.wdata[acp_pkg::CA_ERR_RESET]) | io_stop_mode |
                       ((c == 0) && dcd_hi);

      always_ff @(posedge ref_clk or negedge rstn) begin
         if (!rstn) begin
            ctrl_a_ff[c] <= acp_pkg::RST_CTRL_A;
            ctrl_b_ff[c] <= acp_pkg::RST_CTRL_B;
            rie_ff       <= 1'b0;
            tie_ff       <= 1'b0;
         end else begin
            if (wr_a) ctrl_a_ff[c] <= io_req.wdata;
            if (wr_b) ctrl_b_ff[c] <= io_req.wdata;
            if (wr_s) begin
               rie_ff <= io_req.wdata[acp_pkg::ST_RX_IE];
               tie_ff <= io_req.wdata[acp_pkg::ST_TX_IE];
            end
         end
      end

      // prescaler and pin clock
      always_ff @(posedge ref_clk or negedge rstn) begin
         if (!rstn) begin
            ps_cnt_ff <= 6'h00;
            ck_tgl_ff <= 1'b0;
         end else begin
            ps_cnt_ff <= (tick || ext_sel) ? 6'h00 : ps_cnt_ff + 6'h01;
            if (tick) ck_tgl_ff <= ~ck_tgl_ff;
         end
      end

      // shared clock pin: dma sharing first, then input or driven clock
      always_comb begin
         nxt_ck_o[c]  = ck_tgl_ff;
         nxt_ck_oe[c] = ~ext_sel;
         if (c == 0 && ck0_dma_sel) begin
            nxt_ck_oe[c] = 1'b0;
         end else if (c == 1 && ck1_dma_sel) begin
            nxt_ck_o[c]  = dma_end_out_0;
            nxt_ck_oe[c] = 1'b1;
         end else if (c == 1 && ctrl_a_ff[c][acp_pkg::CA_RTS_CKDIS]) begin
            nxt_ck_oe[c] = 1'b0;
         end
      end

      // transmit data register and shifter
      always_ff @(posedge ref_clk or negedge rstn) begin
         if (!rstn) begin
            tdr_ff      <= 8'h00;
            tdr_full_ff <= 1'b0;
            tx_busy_ff  <= 1'b0;
            tx_sh_ff    <= 12'hfff;
            tx_left_ff  <= 4'h0;
            tx_sub_ff   <= 7'h00;
         end else begin
            if (!tx_busy_ff && tdr_full_ff && !cts_hi && !io_stop_mode &&
                ctrl_a_ff[c][acp_pkg::CA_TX_ENABLE]) begin
               tdr_full_ff <= 1'b0;
               tx_busy_ff  <= 1'b1;
               tx_sub_ff   <= 7'h00;
               tx_sh_ff    <= data8 ? {2'h3, mp ? ctrl_b_ff[c][acp_pkg::CB_MP_TX_BIT] :
                                       ^tdr_ff ^ ctrl_b_ff[c][acp_pkg::CB_PARITY_ODD] | ~par_en,
                                       tdr_ff, 1'b0}
                                    : {3'h7, mp ? ctrl_b_ff[c][acp_pkg::CB_MP_TX_BIT] :
                                       ^tdr_ff[6:0] ^ ctrl_b_ff[c][acp_pkg::CB_PARITY_ODD] |
                                       ~par_en, tdr_ff[6:0], 1'b0};
               tx_left_ff  <= 4'h2 + nbits + {3'h0, ctrl_a_ff[c][acp_pkg::CA_STOP2]};
            end else if (tx_busy_ff && tick) begin
               if (tx_sub_ff == osr - 7'h01) begin
                  tx_sub_ff  <= 7'h00;
                  tx_sh_ff   <= {1'b1, tx_sh_ff[11:1]};
                  tx_left_ff <= tx_left_ff - 4'h1;
                  if (tx_left_ff == 4'h1) tx_busy_ff <= 1'b0;
               end else begin
                  tx_sub_ff <= tx_sub_ff + 7'h01;
               end
            end
            if (io_stop_mode) tdr_full_ff <= 1'b0;
            if (wr_t) begin
               tdr_ff      <= io_req.wdata;
               tdr_full_ff <= 1'b1;
            end
         end
      end

      // receiver: mid-bit sampling from the start edge
      always_ff @(posedge ref_clk or negedge rstn) begin
         if (!rstn) begin
            rx_st_ff  <= acp_pkg::RX_IDLE;
            rx_sub_ff <= 7'h00;
            rx_idx_ff <= 4'h0;
            rx_sh_ff  <= 9'h000;
         end else if (!rx_on) begin
            rx_st_ff <= acp_pkg::RX_IDLE;
         end else if (tick) begin
            rx_sub_ff <= rx_sub_ff + 7'h01;
            case (rx_st_ff)
               acp_pkg::RX_IDLE: begin
                  rx_sub_ff <= 7'h00;
                  if (!rxd_s) rx_st_ff <= acp_pkg::RX_START;
               end
               acp_pkg::RX_START: begin
                  if (rx_sub_ff == (osr >> 1)) begin
                     rx_sub_ff <= 7'h00;
                     rx_idx_ff <= 4'h0;
                     rx_st_ff  <= rxd_s ? acp_pkg::RX_IDLE : acp_pkg::RX_BITS;
                  end
               end
               acp_pkg::RX_BITS: begin
                  if (rx_sub_ff == osr - 7'h01) begin
                     rx_sub_ff           <= 7'h00;
                     rx_sh_ff[rx_idx_ff] <= rxd_s;
                     rx_idx_ff           <= rx_idx_ff + 4'h1;
                     if (rx_idx_ff == nbits - 4'h1) rx_st_ff <= acp_pkg::RX_STOP;
                  end
               end
               acp_pkg::RX_STOP: begin
                  if (rx_sub_ff == osr - 7'h01) rx_st_ff <= acp_pkg::RX_IDLE;
               end
               default: rx_st_ff <= acp_pkg::RX_IDLE;
            endcase
         end
      end

      assign done    = rx_on && tick && rx_st_ff == acp_pkg::RX_STOP && rx_sub_ff == osr - 7'h01;
      assign rx_data = data8 ? rx_sh_ff[7:0] : {1'b0, rx_sh_ff[6:0]};
      assign rx_x    = data8 ? rx_sh_ff[8] : rx_sh_ff[7];
      assign perr    = par_en & (^rx_data ^ rx_x ^ ctrl_b_ff[c][acp_pkg::CB_PARITY_ODD]);
      // address filter drops data characters in multiprocessor mode
      assign keep    = done & ~(ctrl_a_ff[c][acp_pkg::CA_MP_ENABLE] & mp & ~rx_x);
      assign buf_full = cnt_ff == (AW + 1)'(RX_BUF_DEPTH);
      assign push    = keep & ~buf_full;
      assign pop     = rd_r & (cnt_ff != '0);

      // receive buffer of RX_BUF_DEPTH entries, two by default
      always_ff @(posedge ref_clk or negedge rstn) begin
         if (!rstn) begin
            wp_ff  <= '0;
            rp_ff  <= '0;
            cnt_ff <= '0;
         end else begin
            if (push) wp_ff <= wp_ff + 1'b1;
            if (pop) rp_ff <= rp_ff + 1'b1;
            cnt_ff <= cnt_ff + (AW + 1)'(push) - (AW + 1)'(pop);
         end
      end

      always_ff @(posedge ref_clk) begin
         if (push) mem_ff[wp_ff] <= rx_data;
      end

      // error flags, set wins over clear
      always_ff @(posedge ref_clk or negedge rstn) begin
         if (!rstn) begin
            overrun_flag_ff      <= 1'b0;
            pe_ff        <= 1'b0;
            fe_ff        <= 1'b0;
            mpb_rx_ff[c] <= 1'b0;
            dcd_rise_ff  <= 1'b0;
         end else begin
            if (err_clr) begin
               overrun_flag_ff <= 1'b0;
               pe_ff   <= 1'b0;
               fe_ff   <= 1'b0;
            end
            if (keep && buf_full) overrun_flag_ff <= 1'b1;
            if (keep && perr) pe_ff <= 1'b1;
            if (keep && !rxd_s) fe_ff <= 1'b1;
            if (keep) mpb_rx_ff[c] <= rx_x;
            if (rd_s) dcd_rise_ff <= 1'b0;
            if (c == 0 && dcd_hi && !dcd_prev_ff) dcd_rise_ff <= 1'b1;
         end
      end

      assign rx_head[c] = mem_ff[rp_ff];
      assign status[c]  = {cnt_ff != '0, overrun_flag_ff, pe_ff, fe_ff, rie_ff,
                           (c == 0) ? dcd_hi : clear_to_send_ch1_sel_ff, tx_empty_flag, tie_ff};

      always_comb begin
         nxt_ch_out[c].txd        = tx_busy_ff ? tx_sh_ff[0] : 1'b1;
         nxt_ch_out[c].irq        = (rie_ff & (((cnt_ff != '0) & ~((c == 0) &&
                                     ext_ff[acp_pkg::EXT_RX_FULL_INH])) | overrun_flag_ff |
                                     pe_ff | fe_ff | dcd_rise_ff)) | (tie_ff & tx_empty_flag);
         nxt_ch_out[c].rx_dma_req = (cnt_ff != '0) & ~(pe_ff | fe_ff | overrun_flag_ff);
         nxt_ch_out[c].tx_dma_req = tx_empty_flag;
      end
   end
endmodule : acp_top

// [tb/acp_serial_peer.sv]
// remote serial peer: sends frames on rxd, captures frames from txd
`timescale 1ns/1ps
module acp_serial_peer (
   // clock and line pins
   input  wire logic clk,
   input  wire logic txd,
   output logic      rxd
);
   initial rxd = 1'b1;
   // start low, lsb first, stop high unless a bad stop is asked for
   task automatic send(input logic [7:0] d, input bit bad, input int bt);
      logic [9:0] f;
      f = {~bad, d, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rxd <= f[i];
         repeat (bt) @(posedge clk);
      end
      rxd <= 1'b1;
      #1;
   endtask : send
   // samples mid-bit; ok drops on a missing start or stop
   task automatic recv(input int nb, input int bt, output logic [9:0] d, output bit ok);
      int n;
      d = '0;
      n = 0;
      while (txd === 1'b1 && n < 4000) begin
         @(posedge clk);
         n++;
      end
      repeat (bt / 2) @(posedge clk);
      ok = (txd === 1'b0) && (n < 4000);
      for (int i = 0; i < nb; i++) begin
         repeat (bt) @(posedge clk);
         d[i] = txd;
      end
      repeat (bt) @(posedge clk);
      ok = ok && (txd === 1'b1);
   endtask : recv
endmodule : acp_serial_peer

// [tb/acp_asserts.sv]
// port checks of the serial channel pair
`timescale 1ns/1ps
module acp_asserts (
   // clock and reset
   input wire logic                       ref_clk,
   input wire logic                       rstn,
   // register port and modem pins
   input wire acp_pkg::acp_io_req_s       io_req,
   input wire logic [7:0]                 io_rdata_ff,
   input wire logic                       io_stop_mode,
   input wire logic                       carrier_detect_ch0_n,
   input wire logic                       clear_to_send_ch0_n,
   input wire logic                       request_to_send_ch0_n_ff,
   // dma sharing and channel outputs
   input wire logic                       ck0_dma_sel,
   input wire logic                       dma_request_in_0_ff,
   input wire acp_pkg::acp_ch_out_s [1:0] ch_out_ff
);
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);
   sequence s_rd_st0;
      io_req.rd && io_req.addr[5:0] == 6'h04;
   endsequence
   property p_unmapped;
      io_req.rd && io_req.addr[5:0] inside {6'h06, 6'h07, [6'h0a:6'h11]}
         |=> io_rdata_ff == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_ext_bit1;
      io_req.rd && io_req.addr[5:0] == 6'h12 |=> !io_rdata_ff[1];
   endproperty
   a_ext_bit1: assert property (p_ext_bit1) else $error("ext bit1 set");
   property p_rts;
      io_req.wr && io_req.addr[5:0] == 6'h00 && !io_req.wdata[4]
         |-> ##[1:2] !request_to_send_ch0_n_ff;
   endproperty
   a_rts: assert property (p_rts) else $error("rts not following control");
   property p_dma_idle;
      !ck0_dma_sel [*3] |-> dma_request_in_0_ff;
   endproperty
   a_dma_idle: assert property (p_dma_idle) else $error("dma request low unselected");
   property p_stop_tx_empty_flag;
      (io_stop_mode && !clear_to_send_ch0_n) [*4] ##0 s_rd_st0 |=> io_rdata_ff[1];
   endproperty
   a_stop_tx_empty_flag: assert property (p_stop_tx_empty_flag) else $error("tx empty low in stop");
   property p_cts_tx_empty_flag;
      (clear_to_send_ch0_n && !io_stop_mode) [*5] ##0 s_rd_st0 |=> !io_rdata_ff[1];
   endproperty
   a_cts_tx_empty_flag: assert property (p_cts_tx_empty_flag) else $error("tx empty high with cts");
   property p_carrier_fe;
      carrier_detect_ch0_n [*5] ##0 s_rd_st0 |=> !io_rdata_ff[4];
   endproperty
   a_carrier_fe: assert property (p_carrier_fe) else $error("framing flag kept");
   property p_rx_dma_err;
      s_rd_st0 ##1 (io_rdata_ff[6:4] != 3'h0) |-> !ch_out_ff[0].rx_dma_req;
   endproperty
   a_rx_dma_err: assert property (p_rx_dma_err) else $error("rx dma with error");
endmodule : acp_asserts
bind acp_top acp_asserts acp_asserts_inst (.ref_clk, .rstn, .io_req, .io_rdata_ff,
   .io_stop_mode, .carrier_detect_ch0_n, .clear_to_send_ch0_n, .request_to_send_ch0_n_ff,
   .ck0_dma_sel, .dma_request_in_0_ff, .ch_out_ff);

// [tb/tb.sv]
// self-checking bench of the serial channel pair
`timescale 1ns/1ps
module tb;
   logic                       ref_clk = 1'b0;
   logic                       rstn = 1'b0;
   acp_pkg::acp_io_req_s       io_req = '0;
   logic                       stop = 1'b0;
   logic                       dcd_n = 1'b0;
   logic                       cts_n = 1'b0;
   logic                       dsel = 1'b0;
   logic                       rx0;
   logic [7:0]                 rdata;
   logic                       csr;
   logic [1:0]                 oe;
   acp_pkg::acp_ch_out_s [1:0] ch_out;
   int                         failures = 0;
   int                         n_compared = 0;
   int                         seed = 42533;
   logic [7:0]                 q, v;
   logic [7:0]                 b [3];
   logic [9:0]                 f;
   bit                         ok;
   logic [15:0]                fmts [5] = '{16'h6400, 16'h6000, 16'h6600, 16'h6610, 16'h6509};
   always #2 ref_clk = ~ref_clk;
   acp_top acp_top_inst (.ref_clk(ref_clk), .rstn(rstn), .io_req(io_req),
      .io_rdata_ff(rdata), .io_stop_mode(stop), .rxd({1'b1, rx0}),
      .carrier_detect_ch0_n(dcd_n), .clear_to_send_ch0_n(cts_n), .clear_to_send_ch1_shared_n(1'b0),
      .request_to_send_ch0_n_ff(), .clocked_serial_rx_in_ff(csr), .ck_pin_i(2'h0),
      .ck_pin_o_ff(), .ck_pin_oe_ff(oe), .ck0_dma_sel(dsel), .ck1_dma_sel(1'b0),
      .dma_request_in_0_ff(), .dma_end_out_0(1'b0), .ch_out_ff(ch_out));
   acp_serial_peer acp_serial_peer_inst (.clk(ref_clk), .txd(ch_out[0].txd), .rxd(rx0));
   task automatic check(input logic [9:0] seen, input logic [9:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : check
   task automatic end_of_test();
      if (failures == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_of_test
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : tick
   task automatic op(input logic [5:0] a, input logic w, input logic [7:0] d);
      io_req = '{{2'h0, a}, w, ~w, d};
      tick(1);
      io_req = '0;
      q = rdata;
      tick(1);
   endtask : op
   task automatic rchk(input logic [5:0] a, input logic [7:0] m, input logic [7:0] e);
      op(a, 1'b0, 8'h00);
      check({2'h0, q & m}, {2'h0, e});
   endtask : rchk
   task automatic irq(input logic e);
      tick(4);
      check({9'h0, ch_out[0].irq}, {9'h0, e});
   endtask : irq
   // expected character bits with optional parity above the data
   function automatic logic [9:0] frame(input logic [7:0] c, input logic [15:0] fm);
      int         n;
      logic [9:0] r;
      n = fm[10] ? 8 : 7;
      r = {2'h0, c} & ((10'h1 << n) - 10'h1);
      if (fm[9]) r[n] = (^r) ^ fm[4];
      return r;
   endfunction : frame
   initial begin
      repeat (8) @(posedge ref_clk);
      #1 rstn = 1'b1;
      tick(4);
      rchk(6'h01, 8'hff, 8'h10);
      rchk(6'h02, 8'hff, 8'h00);
      rchk(6'h04, 8'hfb, 8'h02);
      rchk(6'h12, 8'hff, 8'h00);
      check({9'h0, csr}, 10'h0);
      op(6'h05, 1'b1, 8'h04);
      check({9'h0, csr}, 10'h1);
      op(6'h0a, 1'b1, 8'h5a);
      rchk(6'h0a, 8'hff, 8'h00);
      op(6'h12, 1'b1, 8'hff);
      rchk(6'h12, 8'hff, 8'hfd);
      op(6'h12, 1'b1, 8'h00);
      check({8'h0, oe}, 10'h1);
      dsel = 1'b1;
      tick(4);
      check({8'h0, oe}, 10'h0);
      dsel = 1'b0;
      for (int i = 0; i < 5; i++) begin
         op(6'h00, 1'b1, fmts[i][15:8]);
         op(6'h02, 1'b1, fmts[i][7:0]);
         v = 8'($random(seed));
         fork
            acp_serial_peer_inst.recv((fmts[i][10] ? 8 : 7) + int'(fmts[i][9]),
               (fmts[i][3] ? 64 : 16) << fmts[i][2:0], f, ok);
            op(6'h06, 1'b1, v);
         join
         check(f, frame(v, fmts[i]));
         check({9'h0, ok}, 10'h1);
         if (!ok) end_of_test();
         tick(200);
      end
      rchk(6'h03, 8'hff, 8'h00);
      op(6'h00, 1'b1, 8'h64);
      op(6'h02, 1'b1, 8'h00);
      op(6'h04, 1'b1, 8'h01);
      irq(1'b1);
      cts_n = 1'b1;
      irq(1'b0);
      check({9'h0, ch_out[0].tx_dma_req}, 10'h0);
      rchk(6'h04, 8'h02, 8'h00);
      cts_n = 1'b0;
      op(6'h04, 1'b1, 8'h08);
      v = 8'($random(seed));
      acp_serial_peer_inst.send(v, 1'b0, 16);
      irq(1'b1);
      check({9'h0, ch_out[0].rx_dma_req}, 10'h1);
      op(6'h12, 1'b1, 8'h80);
      irq(1'b0);
      op(6'h12, 1'b1, 8'h00);
      rchk(6'h08, 8'hff, v);
      irq(1'b0);
      dcd_n = 1'b1;
      irq(1'b1);
      rchk(6'h04, 8'h10, 8'h00);
      irq(1'b0);
      dcd_n = 1'b0;
      op(6'h04, 1'b1, 8'h00);
      tick(6);
      acp_serial_peer_inst.send(8'($random(seed)), 1'b1, 16);
      rchk(6'h04, 8'h10, 8'h10);
      dcd_n = 1'b1;
      tick(4);
      rchk(6'h04, 8'h10, 8'h00);
      dcd_n = 1'b0;
      op(6'h08, 1'b0, 8'h00);
      for (int k = 0; k < 3; k++) begin
         b[k] = 8'($random(seed));
         acp_serial_peer_inst.send(b[k], 1'b0, 16);
      end
      rchk(6'h04, 8'hc0, 8'hc0);
      rchk(6'h08, 8'hff, b[0]);
      rchk(6'h08, 8'hff, b[1]);
      op(6'h00, 1'b1, 8'h64);
      rchk(6'h04, 8'hf0, 8'h00);
      op(6'h06, 1'b1, 8'($random(seed)));
      op(6'h06, 1'b1, 8'h00);
      rchk(6'h04, 8'h02, 8'h00);
      stop = 1'b1;
      tick(4);
      rchk(6'h04, 8'h02, 8'h02);
      stop = 1'b0;
      tick(300);
      end_of_test();
   end
endmodule : tb
